// ===== design/ndid_regs.sv
`timescale 1ns/1ns
`include "ndid_defs.svh"
module ndid_regs
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_bus_reset,
  input wire logic i_selfid_done,
  input wire logic [5:0] i_phy_node_index,
  input wire logic i_phy_is_root,
  input wire logic i_cable_power_ok,
  input wire logic i_phy_reg_rx,
  input wire logic [3:0] i_phy_reg_rx_index,
  input wire logic [7:0] i_phy_reg_rx_value,
  output logic o_phy_req_valid,
  output logic o_phy_req_is_write,
  output logic [3:0] o_phy_req_index,
  output logic [7:0] o_phy_req_value,
  input wire logic i_phy_req_accept,
  output logic [15:0] o_node_id,
  output logic o_node_id_valid,
  output logic o_node_index_max,
  output logic o_irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic valid_q;
  logic root_q;
  logic cps_q;
  logic [9:0] seg_q;
  logic [5:0] idx_q;
  logic idx_max_q;
  logic done_q;
  logic done_d;
  logic [3:0] ra_q;
  logic [7:0] rv_q;
  logic rdreq_q;
  logic rdreq_d;
  logic wrreq_q;
  logic wrreq_d;
  logic [3:0] ta_q;
  logic [7:0] wv_q;
  logic [`NDID_EV_W-1:0] stat_q;
  logic [`NDID_EV_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic req_valid_q;
  logic req_write_q;
  logic [3:0] req_index_q;
  logic [7:0] req_value_q;
  ndid_pkg::ndid_req_st_t st_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr_node = i_wr && (i_addr == `NDID_OFS_NODE);
  wire wr_phy = i_wr && (i_addr == `NDID_OFS_PHY);
  wire wr_istat = i_wr && (i_addr == `NDID_OFS_ISTAT);
  wire wr_imask = i_wr && (i_addr == `NDID_OFS_IMASK);
  wire sw_req = wr_phy && (i_wdata[`NDID_B_RDREQ] || i_wdata[`NDID_B_WRREQ]);
  wire idle_req = (st_q == ndid_pkg::NDID_ST_IDLE) && (rdreq_q || wrreq_q);
  wire sent = (st_q == ndid_pkg::NDID_ST_SEND) && i_phy_req_accept;
  wire [`NDID_EV_W-1:0] ev = {i_phy_reg_rx, i_selfid_done, i_bus_reset};

  // reserved bits held at zero in all four read views
  wire [31:0] node_view = {valid_q, root_q, 2'b00, cps_q, 11'h000, seg_q, idx_q};
  wire [31:0] phy_view = {done_q, 3'b000, ra_q, rv_q, rdreq_q, wrreq_q, 2'b00, ta_q, wv_q};
  wire [31:0] stat_view = {{(32-`NDID_EV_W){1'b0}}, stat_q};
  wire [31:0] mask_view = {{(32-`NDID_EV_W){1'b0}}, mask_q};
  wire [31:0] rdata_d = !i_rd ? 32'h0000_0000 :
                        (i_addr == `NDID_OFS_NODE) ? node_view :
                        (i_addr == `NDID_OFS_PHY) ? phy_view :
                        (i_addr == `NDID_OFS_ISTAT) ? stat_view :
                        (i_addr == `NDID_OFS_IMASK) ? mask_view :
                        32'h0000_0000;

  // ----------------------------------------
  // node identity
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      valid_q <= 1'b0;
      root_q <= 1'b0;
      idx_q <= `NDID_IDX_RST;
      idx_max_q <= 1'b0;
    end
    else if (i_selfid_done)
    begin
      valid_q <= 1'b1;
      root_q <= i_phy_is_root;
      idx_q <= i_phy_node_index;
      idx_max_q <= (i_phy_node_index == `NDID_IDX_MAX);
    end
    else if (i_bus_reset)
    begin
      valid_q <= 1'b0;
      root_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cps_q <= 1'b0;
      seg_q <= `NDID_SEG_RST;
    end
    else
    begin
      cps_q <= i_cable_power_ok;
      if (wr_node)
      begin
        seg_q <= i_wdata[`NDID_SEG_HI:`NDID_SEG_LO];
      end
    end
  end

  // ----------------------------------------
  // phy register access
  // ----------------------------------------
  // arrival wins over a software clear in the same cycle
  always_comb
  begin
    done_d = done_q;
    if (sw_req)
    begin
      done_d = 1'b0;
    end
    if (i_phy_reg_rx)
    begin
      done_d = 1'b1;
    end
  end

  // a software write in the cycle of acceptance keeps the new request
  always_comb
  begin
    rdreq_d = rdreq_q;
    wrreq_d = wrreq_q;
    if (sent)
    begin
      rdreq_d = 1'b0;
      wrreq_d = 1'b0;
    end
    if (wr_phy)
    begin
      rdreq_d = i_wdata[`NDID_B_RDREQ];
      wrreq_d = i_wdata[`NDID_B_WRREQ];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      done_q <= 1'b0;
      ra_q <= 4'h0;
      rv_q <= 8'h00;
      rdreq_q <= 1'b0;
      wrreq_q <= 1'b0;
      ta_q <= 4'h0;
      wv_q <= 8'h00;
    end
    else
    begin
      done_q <= done_d;
      rdreq_q <= rdreq_d;
      wrreq_q <= wrreq_d;
      if (i_phy_reg_rx)
      begin
        ra_q <= i_phy_reg_rx_index;
        rv_q <= i_phy_reg_rx_value;
      end
      if (wr_phy)
      begin
        ta_q <= i_wdata[`NDID_TA_HI:`NDID_TA_LO];
        wv_q <= i_wdata[`NDID_WV_HI:0];
      end
    end
  end

  // ----------------------------------------
  // request sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= ndid_pkg::NDID_ST_IDLE;
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_index_q <= 4'h0;
      req_value_q <= 8'h00;
    end
    else
    begin
      case (st_q)
        ndid_pkg::NDID_ST_IDLE:
        begin
          if (idle_req)
          begin
            st_q <= ndid_pkg::NDID_ST_SEND;
            req_valid_q <= 1'b1;
            req_write_q <= !rdreq_q;
            req_index_q <= ta_q;
            req_value_q <= rdreq_q ? 8'h00 : wv_q;
          end
        end
        ndid_pkg::NDID_ST_SEND:
        begin
          if (i_phy_req_accept)
          begin
            st_q <= ndid_pkg::NDID_ST_IDLE;
            req_valid_q <= 1'b0;
          end
        end
        default:
        begin
          st_q <= ndid_pkg::NDID_ST_IDLE;
          req_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NDID_EV_W; gi = gi + 1)
    begin : g_ev
      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          stat_q[gi] <= 1'b0;
          mask_q[gi] <= 1'b0;
        end
        else
        begin
          stat_q[gi] <= ev[gi] || (stat_q[gi] && !(wr_istat && i_wdata[gi]));
          if (wr_imask)
          begin
            mask_q[gi] <= i_wdata[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // read data and interrupt line
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_phy_req_valid = req_valid_q;
  assign o_phy_req_is_write = req_write_q;
  assign o_phy_req_index = req_index_q;
  assign o_phy_req_value = req_value_q;
  assign o_node_id = {seg_q, idx_q};
  assign o_node_id_valid = valid_q;
  assign o_node_index_max = idx_max_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_rd_pending;
    (st_q == ndid_pkg::NDID_ST_IDLE) && rdreq_q;
  endsequence

  sequence s_wr_pending;
    (st_q == ndid_pkg::NDID_ST_IDLE) && wrreq_q && !rdreq_q;
  endsequence

  sequence s_sent_clean;
    req_valid_q && i_phy_req_accept && !wr_phy;
  endsequence

  AST_VALID_CLR:
  assert property (i_bus_reset && !i_selfid_done |=> !valid_q && !o_node_id_valid)
  else $error("valid flag not cleared by bus reset");

  AST_IDX_LOAD:
  assert property (i_selfid_done |=> valid_q && idx_q == $past(i_phy_node_index))
  else $error("node index not loaded after self-id");

  AST_IDX_HOLD:
  assert property (wr_node && !i_selfid_done |=> idx_q == $past(idx_q))
  else $error("node index changed by software");

  AST_ROOT:
  assert property (i_selfid_done |=> root_q == $past(i_phy_is_root))
  else $error("root flag mismatch");

  AST_CPS:
  assert property (i_cable_power_ok |=> cps_q ##1 (o_rdata[`NDID_B_CPS] || !$past(i_rd && i_addr == `NDID_OFS_NODE)))
  else $error("cable power flag not set");

  AST_NODE_RSVD:
  assert property (i_rd && i_addr == `NDID_OFS_NODE |=> o_rdata[29:28] == 2'b00 && o_rdata[26:16] == 11'h000)
  else $error("node identity reserved bits not zero");

  AST_SEG_WR:
  assert property (wr_node |=> o_node_id[15:6] == $past(i_wdata[`NDID_SEG_HI:`NDID_SEG_LO]))
  else $error("bus segment id not written");

  AST_DONE_CLR:
  assert property (sw_req && !i_phy_reg_rx |=> !done_q)
  else $error("read complete flag not cleared");

  AST_DONE_SET:
  assert property (i_phy_reg_rx |=> done_q && ra_q == $past(i_phy_reg_rx_index) && rv_q == $past(i_phy_reg_rx_value))
  else $error("phy transfer not captured");

  AST_RD_ISSUE:
  assert property (s_rd_pending |=> o_phy_req_valid && !o_phy_req_is_write && o_phy_req_index == $past(ta_q))
  else $error("read request not issued");

  AST_WR_ISSUE:
  assert property (s_wr_pending |=> o_phy_req_valid && o_phy_req_is_write && o_phy_req_value == $past(wv_q))
  else $error("write request not issued");

  AST_REQ_CLR:
  assert property (s_sent_clean |=> !rdreq_q && !wrreq_q && !o_phy_req_valid)
  else $error("request bits not cleared after send");

  AST_READ_PRIO:
  assert property (s_rd_pending ##0 wrreq_q |=> !o_phy_req_is_write ##1 !rdreq_q || o_phy_req_valid)
  else $error("write issued alongside read");

  AST_RD_VALUE:
  assert property (o_phy_req_valid && !o_phy_req_is_write |-> o_phy_req_value == 8'h00)
  else $error("read request carries data");

  AST_PHY_RSVD:
  assert property (i_rd && i_addr == `NDID_OFS_PHY |=> o_rdata[30:28] == 3'b000 && o_rdata[13:12] == 2'b00)
  else $error("access register reserved bits not zero");

  AST_IRQ: 
  assert property (|(stat_q & mask_q) |=> o_irq)
  else $error("interrupt not raised");

endmodule

// ===== design/ndid_defs.svh
`ifndef NDID_DEFS_SVH
`define NDID_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define NDID_OFS_ISTAT 8'h00
`define NDID_OFS_IMASK 8'h04
`define NDID_OFS_NODE 8'he8
`define NDID_OFS_PHY 8'hec
// ----------------------------------------
// node identity fields
// ----------------------------------------
`define NDID_B_VALID 31
`define NDID_B_ROOT 30
`define NDID_B_CPS 27
`define NDID_SEG_HI 15
`define NDID_SEG_LO 6
`define NDID_IDX_HI 5
`define NDID_SEG_RST 10'h3ff
`define NDID_IDX_RST 6'h00
`define NDID_IDX_MAX 6'h3f
// ----------------------------------------
// phy register access fields
// ----------------------------------------
`define NDID_B_DONE 31
`define NDID_RA_HI 27
`define NDID_RA_LO 24
`define NDID_RV_HI 23
`define NDID_RV_LO 16
`define NDID_B_RDREQ 15
`define NDID_B_WRREQ 14
`define NDID_TA_HI 11
`define NDID_TA_LO 8
`define NDID_WV_HI 7
`define NDID_PHY_RST 32'h0000_0000
// ----------------------------------------
// interrupt events
// ----------------------------------------
`define NDID_EV_BRST 0
`define NDID_EV_NODE 1
`define NDID_EV_DONE 2
`define NDID_EV_W 3
`endif

// ===== design/ndid_pkg.sv
package ndid_pkg;
  typedef enum logic [0:0]
  {
    NDID_ST_IDLE = 1'b0,
    NDID_ST_SEND = 1'b1
  } ndid_req_st_t;
endpackage

// ===== tb/ndid_phy_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// physical layer register file model
// ----------------------------------------
module ndid_phy_model
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_req_valid,
  input wire logic i_req_is_write,
  input wire logic [3:0] i_req_index,
  input wire logic [7:0] i_req_value,
  output logic o_accept,
  output logic o_rx,
  output logic [3:0] o_rx_index,
  output logic [7:0] o_rx_value
);
  logic [7:0] regs_q [16];
  logic [1:0] wait_q;
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 16; k++)
        regs_q[k] <= 8'(k * 8'h11);
      wait_q <= 2'h0;
      o_accept <= 1'b0;
      o_rx <= 1'b0;
      o_rx_index <= 4'h0;
      o_rx_value <= 8'h00;
    end
    else
    begin
      o_accept <= 1'b0;
      o_rx <= 1'b0;
      o_rx_index <= ~o_rx_index;
      o_rx_value <= ~o_rx_value;
      if (i_req_valid && !o_accept)
      begin
        if (wait_q == (i_slow ? 2'h3 : 2'h0))
        begin
          o_accept <= 1'b1;
          wait_q <= 2'h0;
          if (i_req_is_write)
            regs_q[i_req_index] <= i_req_value;
          else
          begin
            o_rx <= 1'b1;
            o_rx_index <= i_req_index;
            o_rx_value <= regs_q[i_req_index];
          end
        end
        else
          wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
`include "ndid_defs.svh"
module testbench;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, slow = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic bus_reset = 1'b0, selfid = 1'b0, is_root = 1'b0, cable_power_ok = 1'b0;
  logic [5:0] node_index = 6'h00;
  logic rx, req_valid, req_wr, accept, node_valid, idx_max, o_irq;
  logic [3:0] rx_index, req_index;
  logic [7:0] rx_value, req_value;
  logic [15:0] node_id;
  int fails = 0, n_compared = 0;
  always #4 i_core_clk = ~i_core_clk;
  ndid_regs i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_reset(bus_reset), .i_selfid_done(selfid),
    .i_phy_node_index(node_index), .i_phy_is_root(is_root), .i_cable_power_ok(cable_power_ok), .i_phy_reg_rx(rx),
    .i_phy_reg_rx_index(rx_index), .i_phy_reg_rx_value(rx_value), .o_phy_req_valid(req_valid),
    .o_phy_req_is_write(req_wr), .o_phy_req_index(req_index), .o_phy_req_value(req_value),
    .i_phy_req_accept(accept), .o_node_id(node_id), .o_node_id_valid(node_valid),
    .o_node_index_max(idx_max), .o_irq(o_irq));
  ndid_phy_model i_phy (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_slow(slow), .i_req_valid(req_valid),
    .i_req_is_write(req_wr), .i_req_index(req_index), .i_req_value(req_value), .o_accept(accept),
    .o_rx(rx), .o_rx_index(rx_index), .o_rx_value(rx_value));
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic wait_req(input logic lvl);
    int k;
    k = 0;
    while (req_valid !== lvl && k < 50)
    begin
      @(posedge i_core_clk);
      #1;
      k++;
    end
    if (req_valid !== lvl)
    begin
      fails++;
      test_done();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(`NDID_OFS_NODE, 32'h0000_ffc0);
    rd(`NDID_OFS_PHY, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    chk({16'h0, node_id}, 32'h0000_ffc0);
    chk({31'h0, idx_max}, 32'h0);
    wr(`NDID_OFS_NODE, 32'hffff_5555);
    rd(`NDID_OFS_NODE, 32'h0000_5540);
    chk({16'h0, node_id}, 32'h0000_5540);
    $display("test reset and write done");
    wr(`NDID_OFS_IMASK, 32'h0000_0002);
    @(posedge i_core_clk);
    cable_power_ok <= 1'b1;
    is_root <= 1'b1;
    node_index <= 6'h3f;
    selfid <= 1'b1;
    @(posedge i_core_clk);
    selfid <= 1'b0;
    rd(`NDID_OFS_NODE, 32'hc800_557f);
    chk({31'h0, idx_max}, 32'h1);
    chk({31'h0, node_valid}, 32'h1);
    chk({31'h0, o_irq}, 32'h1);
    rd(`NDID_OFS_ISTAT, 32'h0000_0002);
    wr(`NDID_OFS_ISTAT, 32'h0000_0002);
    @(posedge i_core_clk);
    #1;
    chk({31'h0, o_irq}, 32'h0);
    @(posedge i_core_clk);
    bus_reset <= 1'b1;
    cable_power_ok <= 1'b0;
    @(posedge i_core_clk);
    bus_reset <= 1'b0;
    rd(`NDID_OFS_NODE, 32'h0000_557f);
    chk({31'h0, node_valid}, 32'h0);
    $display("test node events done");
    wr(`NDID_OFS_PHY, 32'h0000_45a5);
    wait_req(1'b1);
    chk({19'h0, req_wr, req_index, req_value}, 32'h0000_15a5);
    wait_req(1'b0);
    @(posedge i_core_clk);
    rd(`NDID_OFS_PHY, 32'h0000_05a5);
    $display("test phy write done");
    slow <= 1'b1;
    wr(`NDID_OFS_PHY, 32'h0000_85ff);
    wait_req(1'b1);
    chk({19'h0, req_wr, req_index, req_value}, 32'h0000_0500);
    wait_req(1'b0);
    @(posedge i_core_clk);
    rd(`NDID_OFS_PHY, 32'h85a5_05ff);
    wr(`NDID_OFS_PHY, 32'h0000_8500);
    rd(`NDID_OFS_PHY, 32'h05a5_8500);
    wait_req(1'b0);
    @(posedge i_core_clk);
    $display("test phy read done");
    wr(`NDID_OFS_PHY, 32'h0000_c300);
    wait_req(1'b1);
    chk({31'h0, req_wr}, 32'h0);
    wait_req(1'b0);
    @(posedge i_core_clk);
    rd(`NDID_OFS_PHY, 32'h8333_0300);
    rd(`NDID_OFS_ISTAT, 32'h0000_0005);
    $display("test both requests done");
    test_done();
  end
endmodule
